// *** core/hrm_core.sv ***
// Homing reference manager: reference state, homing mode handling and
// absolute position retention for a servo positioning axis.
// Assumes all inputs except rstn synchronous to mclk and a motion controller that
// executes the search, the final move and the brake on request.
`timescale 1ns/1ps

module hrm_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [hrm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [hrm_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [hrm_pkg::DATA_W-1:0] regRdata,
    // Switches and motor feedback signals
    input wire hrm_pkg::hrm_sw_t swRaw,
    input wire logic zeroPulse,
    input wire logic [15:0] motorCurrent,
    input wire logic [31:0] fbAbsPos,
    input wire logic [15:0] fbMovedAngle,
    // Feedback position store
    output logic fbRdReq,
    input wire logic fbRdAck,
    input wire logic [31:0] fbRdData,
    output logic fbWrReq,
    output logic [31:0] fbWrData,
    input wire logic fbWrAck,
    // Motion controller
    input wire logic [31:0] actPos,
    input wire logic motionDone,
    output logic motionStart,
    output logic homeRun,
    output logic searchDir,
    output logic machineZero,
    output logic moveToZero,
    output logic brakeStop,
    output logic posLoad,
    output logic [31:0] posLoadVal,
    // Status
    output logic referencedOutput,
    output logic softLimitEn,
    output logic cfgError,
    output logic [15:0] statusWord
);

    logic [1:0] rstPipe_q;
    logic rstnSync;
    logic [hrm_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0] valWin_q, curThr_q;
    logic [31:0] retPos_q, rdMux, regRdata_q;
    hrm_pkg::hrm_cfg_t cfg;
    hrm_pkg::hrm_fam_t fam;
    hrm_pkg::hrm_sw_t swLog, swPrev_q;
    hrm_pkg::hrm_state_t state_q;
    logic cmdWr, doDownload, doStart, doPowerOn, doClrErr;
    logic modeBad, posSide, withinWin, curHit, homeRise, homeFall, found, revNow;
    logic referenced_q, needHome_q, modeErr_q, dir_q, machineZero_q, motionStart_q, posLoad_q;
    logic [31:0] posLoadVal_q, fbWrData_q;

    // Reset release through two flops.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rstPipe_q <= 2'b00;
        else
            rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
    assign rstnSync = rstPipe_q[1];

    assign cfg = hrm_pkg::hrm_cfg_t'(ctrl_q);
    assign fam = hrm_pkg::hrmFamily(cfg.mode);
    assign modeBad = (fam == hrm_pkg::FAM_BAD);
    assign swLog.home = swRaw.home ^ cfg.invHome;
    assign swLog.posLim = swRaw.posLim ^ cfg.invPos;
    assign swLog.negLim = swRaw.negLim ^ cfg.invNeg;

    assign cmdWr = regWr && (regAddr == hrm_pkg::OFF_CMD);
    assign doDownload = cmdWr && regWdata[hrm_pkg::CMD_DOWNLOAD];
    assign doStart = cmdWr && regWdata[hrm_pkg::CMD_START];
    assign doPowerOn = cmdWr && regWdata[hrm_pkg::CMD_POWERON];
    assign doClrErr = cmdWr && regWdata[hrm_pkg::CMD_CLRERR];

    // Configuration registers.
    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            ctrl_q <= hrm_pkg::CTRL_RST;
            valWin_q <= hrm_pkg::VALWIN_RST;
            curThr_q <= hrm_pkg::CURTHR_RST;
        end
        else if (regWr)
        begin
            if (regAddr == hrm_pkg::OFF_CTRL)
                ctrl_q <= regWdata[hrm_pkg::CTRL_W-1:0];
            else if (regAddr == hrm_pkg::OFF_VALWIN)
                valWin_q <= regWdata[15:0];
            else if (regAddr == hrm_pkg::OFF_CURTHR)
                curThr_q <= regWdata[15:0];
        end
    end

    // Position kept inside the device; it has no reset so it outlives one.
    always_ff @(posedge mclk)
    begin
        if (regWr && regAddr == hrm_pkg::OFF_RETPOS)
            retPos_q <= regWdata;
        else if (state_q == hrm_pkg::S_RESTORE && fbRdAck)
            retPos_q <= fbRdData;
        else if (state_q == hrm_pkg::S_SETTLE && motionDone)
            retPos_q <= actPos;
    end

    // Read path, data valid in the cycle after the strobe.
    always_comb
    begin
        rdMux = '0;
        if (regAddr == hrm_pkg::OFF_CTRL)
            rdMux = {16'h0000, ctrl_q};
        else if (regAddr == hrm_pkg::OFF_VALWIN)
            rdMux = {16'h0000, valWin_q};
        else if (regAddr == hrm_pkg::OFF_CURTHR)
            rdMux = {16'h0000, curThr_q};
        else if (regAddr == hrm_pkg::OFF_STATUS)
        begin
            rdMux[hrm_pkg::STAT_REF] = referenced_q;
            rdMux[hrm_pkg::STAT_HOMING] = homeRun;
            rdMux[hrm_pkg::STAT_MODEERR] = modeErr_q;
            rdMux[hrm_pkg::STAT_NEEDHOME] = needHome_q;
            rdMux[hrm_pkg::STAT_SOFTLIM] = softLimitEn;
            rdMux[hrm_pkg::STAT_BOOT] = (state_q == hrm_pkg::S_WAIT);
        end
        else if (regAddr == hrm_pkg::OFF_RETPOS)
            rdMux = retPos_q;
    end

    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
            regRdata_q <= '0;
        else
            regRdata_q <= regRd ? rdMux : '0;
    end
    assign regRdata = regRdata_q;

    // Switch history for edge detection.
    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
            swPrev_q <= '0;
        else
            swPrev_q <= swLog;
    end
    assign homeRise = swLog.home && !swPrev_q.home;
    assign homeFall = !swLog.home && swPrev_q.home;

    assign posSide = (cfg.mode inside {[hrm_pkg::MODE_SW_LO:hrm_pkg::MODE_SW_POS_HI],
                     [hrm_pkg::MODE_SWREV_LO:hrm_pkg::MODE_SWREV_POS_HI],
                     [hrm_pkg::MODE_ZP_LO:hrm_pkg::MODE_ZP_POS_HI],
                     [hrm_pkg::MODE_ZPREV_LO:hrm_pkg::MODE_ZPREV_POS_HI]})
                     || cfg.mode == hrm_pkg::MODE_LIM_POS
                     || cfg.mode == hrm_pkg::MODE_BLK_POS;
    assign withinWin = (fbMovedAngle <= valWin_q);
    assign curHit = (motorCurrent >= curThr_q);

    // Machine zero detection per mode family.
    always_comb
    begin
        found = 1'b0;
        case (fam)
            hrm_pkg::FAM_SW, hrm_pkg::FAM_SW_REV:
                found = cfg.mode[0] ? homeFall : homeRise;
            hrm_pkg::FAM_ZP, hrm_pkg::FAM_ZP_REV:
                found = zeroPulse && (swLog.home == !cfg.mode[0]);
            hrm_pkg::FAM_LIMIT:
                found = cfg.mode[0] ? (swLog.negLim && !swPrev_q.negLim)
                                    : (swLog.posLim && !swPrev_q.posLim);
            hrm_pkg::FAM_BLOCK:
                found = curHit;
            hrm_pkg::FAM_HERE:
                found = 1'b1;
            hrm_pkg::FAM_OTHER:
                found = zeroPulse;
            default:
                found = 1'b0;
        endcase
    end

    // Direction reversal: limit switches in the reversing families, else current, except in limit and block modes.
    always_comb
    begin
        revNow = 1'b0;
        if (fam == hrm_pkg::FAM_SW_REV || fam == hrm_pkg::FAM_ZP_REV)
            revNow = dir_q ? swLog.posLim : swLog.negLim;
        else if (fam != hrm_pkg::FAM_BLOCK && fam != hrm_pkg::FAM_LIMIT)
            revNow = cfg.curRev && curHit;
    end

    // Homing and power-on sequencing.
    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            state_q <= hrm_pkg::S_WAIT;
            dir_q <= 1'b0;
            machineZero_q <= 1'b0;
            motionStart_q <= 1'b0;
            posLoad_q <= 1'b0;
            posLoadVal_q <= '0;
            fbWrData_q <= '0;
        end
        else
        begin
            machineZero_q <= 1'b0;
            motionStart_q <= 1'b0;
            posLoad_q <= 1'b0;
            case (state_q)
                hrm_pkg::S_WAIT:
                    if (doPowerOn)
                    begin
                        if (cfg.storeFb)
                            state_q <= hrm_pkg::S_RESTORE;
                        else
                        begin
                            state_q <= hrm_pkg::S_IDLE;
                            posLoad_q <= cfg.absEnc || cfg.emu;
                            posLoadVal_q <= cfg.absEnc ? fbAbsPos : retPos_q;
                        end
                    end
                hrm_pkg::S_RESTORE:
                    if (fbRdAck)
                    begin
                        state_q <= hrm_pkg::S_IDLE;
                        posLoad_q <= 1'b1;
                        posLoadVal_q <= fbRdData;
                    end
                hrm_pkg::S_IDLE:
                    if (doStart && !doDownload && !modeBad)
                    begin
                        if (needHome_q)
                        begin
                            state_q <= hrm_pkg::S_SEARCH;
                            dir_q <= (fam == hrm_pkg::FAM_LIMIT || fam == hrm_pkg::FAM_BLOCK)
                                     ? posSide : (posSide ^ swLog.home);
                        end
                        else
                            motionStart_q <= 1'b1;
                    end
                hrm_pkg::S_SEARCH:
                    if (doDownload)
                        state_q <= hrm_pkg::S_IDLE;
                    else if (found)
                    begin
                        state_q <= hrm_pkg::S_SETTLE;
                        machineZero_q <= 1'b1;
                    end
                    else if (revNow)
                        dir_q <= !dir_q;
                hrm_pkg::S_SETTLE:
                    if (doDownload)
                        state_q <= hrm_pkg::S_IDLE;
                    else if (motionDone)
                    begin
                        fbWrData_q <= actPos;
                        state_q <= cfg.storeFb ? hrm_pkg::S_STORE : hrm_pkg::S_IDLE;
                    end
                hrm_pkg::S_STORE:
                    if (fbWrAck)
                        state_q <= hrm_pkg::S_IDLE;
                default:
                    state_q <= hrm_pkg::S_WAIT;
            endcase
        end
    end

    // Referenced flag and homing requirement.
    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            referenced_q <= 1'b0;
            needHome_q <= 1'b0;
        end
        else if (doDownload)
        begin
            referenced_q <= 1'b0;
            needHome_q <= (cfg.mode != hrm_pkg::MODE_NONE);
        end
        else if (state_q == hrm_pkg::S_WAIT && doPowerOn && !cfg.storeFb)
        begin
            referenced_q <= cfg.absEnc || (cfg.emu && withinWin);
            needHome_q <= !cfg.absEnc && !cfg.emu && (cfg.mode != hrm_pkg::MODE_NONE);
        end
        else if (state_q == hrm_pkg::S_RESTORE && fbRdAck)
        begin
            referenced_q <= cfg.absEnc || (cfg.emu && withinWin);
            needHome_q <= 1'b0;
        end
        else if (state_q == hrm_pkg::S_SEARCH)
            referenced_q <= 1'b0;
        else if (state_q == hrm_pkg::S_SETTLE && motionDone)
        begin
            referenced_q <= 1'b1;
            needHome_q <= 1'b0;
        end
    end

    // Sticky configuration error; a new error wins over the clear.
    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
            modeErr_q <= 1'b0;
        else if (modeBad && (doDownload || doStart))
            modeErr_q <= 1'b1;
        else if (doClrErr)
            modeErr_q <= 1'b0;
    end

    // Outputs toward the motion controller and feedback.
    assign homeRun = (state_q == hrm_pkg::S_SEARCH) || (state_q == hrm_pkg::S_SETTLE);
    assign searchDir = dir_q;
    assign machineZero = machineZero_q;
    assign motionStart = motionStart_q;
    assign moveToZero = (state_q == hrm_pkg::S_SETTLE) && cfg.posZero;
    assign brakeStop = (state_q == hrm_pkg::S_SETTLE) && !cfg.posZero;
    assign posLoad = posLoad_q;
    assign posLoadVal = posLoadVal_q;
    assign fbRdReq = (state_q == hrm_pkg::S_RESTORE);
    assign fbWrReq = (state_q == hrm_pkg::S_STORE);
    assign fbWrData = fbWrData_q;

    assign softLimitEn = referenced_q && !homeRun;
    assign referencedOutput = referenced_q;
    assign cfgError = modeErr_q;
    assign statusWord = 16'(referenced_q) << hrm_pkg::SW_REF_BIT;

endmodule

// *** core/hrm_pkg.sv ***
// Constants, types and mode decoding for the homing reference manager.
// Assumes a single 200 MHz clock domain and a simple strobe register port.
package hrm_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_VALWIN = 5'h04;
    localparam logic [4:0] OFF_CURTHR = 5'h08;
    localparam logic [4:0] OFF_CMD = 5'h0c;
    localparam logic [4:0] OFF_STATUS = 5'h10;
    localparam logic [4:0] OFF_RETPOS = 5'h14;

    // Control register: the low CTRL_W bits map onto cfg_t.
    localparam int CTRL_W = 16;
    localparam logic [15:0] CTRL_RST = 16'h0100;
    localparam logic [15:0] VALWIN_RST = 16'h0000;
    localparam logic [15:0] CURTHR_RST = 16'hffff;

    // Command register bits, write-one pulses.
    localparam int CMD_DOWNLOAD = 0;
    localparam int CMD_START = 1;
    localparam int CMD_POWERON = 2;
    localparam int CMD_CLRERR = 3;

    // Status register bits.
    localparam int STAT_REF = 0;
    localparam int STAT_HOMING = 1;
    localparam int STAT_MODEERR = 2;
    localparam int STAT_NEEDHOME = 3;
    localparam int STAT_SOFTLIM = 4;
    localparam int STAT_BOOT = 5;

    // Position of the referenced flag in the drive status word.
    localparam int SW_REF_BIT = 12;

    // Homing mode numbers.
    localparam logic [7:0] MODE_NONE = 8'h00;
    localparam logic [7:0] MODE_OTH_A_LO = 8'h01;
    localparam logic [7:0] MODE_OTH_A_HI = 8'h02;
    localparam logic [7:0] MODE_ZP_LO = 8'h03;
    localparam logic [7:0] MODE_ZP_POS_HI = 8'h04;
    localparam logic [7:0] MODE_ZP_HI = 8'h06;
    localparam logic [7:0] MODE_ZPREV_LO = 8'h07;
    localparam logic [7:0] MODE_ZPREV_POS_HI = 8'h0a;
    localparam logic [7:0] MODE_ZPREV_HI = 8'h0e;
    localparam logic [7:0] MODE_LIM_NEG = 8'h11;
    localparam logic [7:0] MODE_LIM_POS = 8'h12;
    localparam logic [7:0] MODE_SW_LO = 8'h13;
    localparam logic [7:0] MODE_SW_POS_HI = 8'h14;
    localparam logic [7:0] MODE_SW_HI = 8'h16;
    localparam logic [7:0] MODE_SWREV_LO = 8'h17;
    localparam logic [7:0] MODE_SWREV_POS_HI = 8'h1a;
    localparam logic [7:0] MODE_SWREV_HI = 8'h1e;
    localparam logic [7:0] MODE_OTH_B_LO = 8'h21;
    localparam logic [7:0] MODE_OTH_B_HI = 8'h22;
    localparam logic [7:0] MODE_HERE = 8'h23;
    localparam logic [7:0] MODE_BLK_NEG = 8'h80;
    localparam logic [7:0] MODE_BLK_POS = 8'h81;
    localparam logic [7:0] MODE_OTH_C_LO = 8'h82;
    localparam logic [7:0] MODE_OTH_C_HI = 8'h85;

    typedef enum logic [3:0] {
        FAM_NONE = 4'h0,
        FAM_SW = 4'h1,
        FAM_SW_REV = 4'h2,
        FAM_ZP = 4'h3,
        FAM_ZP_REV = 4'h4,
        FAM_LIMIT = 4'h5,
        FAM_BLOCK = 4'h6,
        FAM_HERE = 4'h7,
        FAM_OTHER = 4'h8,
        FAM_BAD = 4'h9
    } hrm_fam_t;

    typedef enum logic [5:0] {
        S_WAIT = 6'h01,
        S_RESTORE = 6'h02,
        S_IDLE = 6'h04,
        S_SEARCH = 6'h08,
        S_SETTLE = 6'h10,
        S_STORE = 6'h20
    } hrm_state_t;

    typedef struct packed {
        logic invNeg;
        logic invPos;
        logic invHome;
        logic curRev;
        logic absEnc;
        logic emu;
        logic storeFb;
        logic posZero;
        logic [7:0] mode;
    } hrm_cfg_t;

    typedef struct packed {
        logic home;
        logic posLim;
        logic negLim;
    } hrm_sw_t;

    function automatic hrm_fam_t hrmFamily(input logic [7:0] m);
        hrm_fam_t f;
        f = FAM_BAD;
        if (m == MODE_NONE)
            f = FAM_NONE;
        else if (m >= MODE_SW_LO && m <= MODE_SW_HI)
            f = FAM_SW;
        else if (m >= MODE_SWREV_LO && m <= MODE_SWREV_HI)
            f = FAM_SW_REV;
        else if (m >= MODE_ZP_LO && m <= MODE_ZP_HI)
            f = FAM_ZP;
        else if (m >= MODE_ZPREV_LO && m <= MODE_ZPREV_HI)
            f = FAM_ZP_REV;
        else if (m == MODE_LIM_NEG || m == MODE_LIM_POS)
            f = FAM_LIMIT;
        else if (m == MODE_BLK_NEG || m == MODE_BLK_POS)
            f = FAM_BLOCK;
        else if (m == MODE_HERE)
            f = FAM_HERE;
        else if ((m >= MODE_OTH_A_LO && m <= MODE_OTH_A_HI)
                 || (m >= MODE_OTH_B_LO && m <= MODE_OTH_B_HI)
                 || (m >= MODE_OTH_C_LO && m <= MODE_OTH_C_HI))
            f = FAM_OTHER;
        return f;
    endfunction

endpackage

// *** tb/hrm_monitor.sv ***
// Assertion checker for the homing reference manager.
// Assumes one clock domain; bound onto hrm_core through its ports.
`timescale 1ns/1ps
module hrm_monitor (
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [4:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Feedback store
    input wire logic fbRdReq,
    input wire logic fbRdAck,
    input wire logic fbWrReq,
    input wire logic fbWrAck,
    input wire logic [31:0] fbWrData,
    // Motion and status
    input wire logic motionDone,
    input wire logic homeRun,
    input wire logic machineZero,
    input wire logic moveToZero,
    input wire logic brakeStop,
    input wire logic referencedOutput,
    input wire logic softLimitEn,
    input wire logic cfgError,
    input wire logic [15:0] statusWord
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic cmdWr;
    assign cmdWr = regWr && regAddr == hrm_pkg::OFF_CMD;
    AST_STATUS_BIT:
    assert property (statusWord == {3'h0, referencedOutput, 12'h000})
        else $error("status word does not mirror the referenced flag");
    AST_SOFTLIM_OFF:
    assert property ((homeRun || !referencedOutput) |-> !softLimitEn)
        else $error("software limits enabled while homing or unreferenced");
    AST_DOWNLOAD_CLEAR:
    assert property (cmdWr && regWdata[hrm_pkg::CMD_DOWNLOAD] |=> !referencedOutput)
        else $error("referenced flag survived a download");
    AST_FINAL_EXCL:
    assert property (machineZero |-> homeRun && (moveToZero ^ brakeStop))
        else $error("home found without exactly one final action");
    AST_MZ_PULSE:
    assert property (machineZero |=> !machineZero)
        else $error("machine zero pulse longer than one cycle");
    AST_SETTLE_END:
    assert property ((moveToZero || brakeStop) && motionDone |=> !homeRun && !moveToZero)
        else $error("settle did not end on motion done");
    AST_FBWR_HOLD:
    assert property (fbWrReq && !fbWrAck |=> fbWrReq && $stable(fbWrData))
        else $error("store write request dropped or changed before ack");
    AST_FBRD_HOLD:
    assert property (fbRdReq && !fbRdAck |=> fbRdReq)
        else $error("store read request dropped before ack");
    AST_RD_IDLE:
    assert property (!regRd |=> regRdata == 32'h00000000)
        else $error("read data present without a read");
    AST_ERR_STICKY:
    assert property (cfgError && !(cmdWr && regWdata[hrm_pkg::CMD_CLRERR]) |=> cfgError)
        else $error("mode error flag cleared on its own");
endmodule
bind hrm_core hrm_monitor mon_u (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .fbRdReq, .fbRdAck, .fbWrReq, .fbWrAck, .fbWrData, .motionDone, .homeRun, .machineZero,
    .moveToZero, .brakeStop, .referencedOutput, .softLimitEn, .cfgError, .statusWord);

// *** tb/hrm_fb_model.sv ***
// Behavioural model of the position store inside the motor feedback.
// Answers each request after LAT+1 cycles with a one-cycle ack.
`timescale 1ns/1ps
module hrm_fb_model #(
    parameter int LAT = 2,
    parameter logic [31:0] INIT = 32'h00000000
) (
    // Clock
    input wire logic mclk,
    // Store requests and answers
    input wire logic fbRdReq,
    output logic fbRdAck,
    output logic [31:0] fbRdData,
    input wire logic fbWrReq,
    input wire logic [31:0] fbWrData,
    output logic fbWrAck
);
    logic [31:0] mem = INIT;
    int cnt = 0;
    initial
    begin
        fbRdAck = 1'b0;
        fbWrAck = 1'b0;
        fbRdData = 32'h00000000;
    end
    // Read data is only meaningful in the ack cycle, so it toggles otherwise.
    always @(posedge mclk)
    begin
        fbRdAck <= 1'b0;
        fbWrAck <= 1'b0;
        fbRdData <= ~fbRdData;
        if ((fbRdReq || fbWrReq) && !fbRdAck && !fbWrAck)
        begin
            cnt <= cnt + 1;
            if (cnt >= LAT)
            begin
                cnt <= 0;
                if (fbWrReq)
                begin
                    mem <= fbWrData;
                    fbWrAck <= 1'b1;
                end
                else
                begin
                    fbRdData <= mem;
                    fbRdAck <= 1'b1;
                end
            end
        end
    end
endmodule

// *** tb/tb_homing_reference_manager.sv ***
// Self-checking bench for the homing reference manager.
// Drives the register port and motion inputs; the feedback store is a model.
`timescale 1ns/1ps
module tb_homing_reference_manager;
    logic mclk, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, zeroPulse = 1'b0, motionDone = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [31:0] regWdata = 32'h00000000, fbAbsPos = 32'h00004321, rdv;
    logic [31:0] actPos = 32'h00000800;
    logic [15:0] motorCurrent = 16'h0000, fbMovedAngle = 16'h0000, statusWord;
    hrm_pkg::hrm_sw_t swRaw = 3'h0;
    logic fbRdReq, fbRdAck, fbWrReq, fbWrAck, motionStart, homeRun, searchDir, machineZero;
    logic moveToZero, brakeStop, posLoad, referencedOutput, softLimitEn, cfgError;
    logic [31:0] regRdata, fbRdData, fbWrData, posLoadVal;
    logic [5:0] ev;
    int err_count = 0, n_tests = 0;
    logic [4:0] raddr [5] = '{5'h00, 5'h04, 5'h08, 5'h18, 5'h10};
    logic [31:0] rexp [5] = '{32'h100, 32'h0, 32'hffff, 32'h0, 32'h20};
    logic [7:0] modes [10] = '{8'h03, 8'h07, 8'h11, 8'h13, 8'h17, 8'h80, 8'h0f, 8'h10, 8'h1f, 8'h86};
    assign ev = {fbWrAck, fbWrReq, motionStart, machineZero, homeRun, posLoad};
    hrm_core dut_u (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .swRaw,
        .zeroPulse, .motorCurrent, .fbAbsPos, .fbMovedAngle, .fbRdReq, .fbRdAck, .fbRdData,
        .fbWrReq, .fbWrData, .fbWrAck, .actPos, .motionDone, .motionStart, .homeRun, .searchDir,
        .machineZero, .moveToZero, .brakeStop, .posLoad, .posLoadVal, .referencedOutput,
        .softLimitEn, .cfgError, .statusWord);
    hrm_fb_model #(.LAT(2), .INIT(32'h00000777)) fb_u (.mclk, .fbRdReq, .fbRdAck, .fbRdData,
        .fbWrReq, .fbWrData, .fbWrAck);
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask
    // Waits for one bit of ev, so one-cycle pulses are not missed.
    task automatic waitEv(input int b);
        int i;
        i = 0;
        #1;
        while (ev[b] !== 1'b1 && i < 60)
        begin
            @(posedge mclk);
            #1;
            i++;
        end
        if (ev[b] !== 1'b1)
        begin
            err_count++;
            $display("wrong value at %0t: event %0d never seen", $time, b);
            conclude();
        end
    endtask
    task automatic doReset();
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask
    task automatic settle();
        @(posedge mclk);
        motionDone <= 1'b1;
        @(posedge mclk);
        motionDone <= 1'b0;
    endtask
    initial
    begin
        doReset();
        wr(hrm_pkg::OFF_STATUS, 32'h00000000);
        wr(5'h18, 32'hffffffff);
        for (int i = 0; i < 5; i++)
        begin
            rd(raddr[i]);
            chk(rdv & (i == 4 ? 32'h20 : 32'hffffffff), rexp[i]);
        end
        wr(hrm_pkg::OFF_CTRL, 32'h00000923);
        wr(hrm_pkg::OFF_CMD, 32'h00000004);
        waitEv(0);
        chk(posLoadVal, 32'h00004321);
        chk(32'(fbRdReq), 32'h0);
        chk(32'({referencedOutput, softLimitEn, statusWord[12]}), 32'h7);
        wr(hrm_pkg::OFF_CMD, 32'h00000001);
        #1 chk(32'({referencedOutput, softLimitEn}), 32'h0);
        wr(hrm_pkg::OFF_CMD, 32'h00000002);
        waitEv(1);
        chk(32'(softLimitEn), 32'h0);
        waitEv(2);
        chk(32'({moveToZero, brakeStop}), 32'h2);
        settle();
        #1 chk(32'({homeRun, referencedOutput}), 32'h1);
        wr(hrm_pkg::OFF_CMD, 32'h00000002);
        waitEv(3);
        chk(32'(homeRun), 32'h0);
        doReset();
        wr(hrm_pkg::OFF_CTRL, 32'h00000a23);
        wr(hrm_pkg::OFF_CMD, 32'h00000004);
        waitEv(0);
        chk(posLoadVal, 32'h00000777);
        wr(hrm_pkg::OFF_CMD, 32'h00000001);
        wr(hrm_pkg::OFF_CMD, 32'h00000002);
        waitEv(2);
        chk(32'({moveToZero, brakeStop}), 32'h1);
        settle();
        waitEv(4);
        chk(fbWrData, actPos);
        waitEv(5);
        chk(fb_u.mem, actPos);
        for (int k = 0; k < 2; k++)
        begin
            doReset();
            fbMovedAngle <= 16'h0010 + 16'(k);
            wr(hrm_pkg::OFF_RETPOS, 32'h00004321);
            wr(hrm_pkg::OFF_VALWIN, 32'h00000010);
            wr(hrm_pkg::OFF_CTRL, 32'h00000500);
            wr(hrm_pkg::OFF_CMD, 32'h00000004);
            waitEv(0);
            chk(posLoadVal, 32'h00004321);
            chk(32'({referencedOutput, softLimitEn}), k ? 32'h0 : 32'h3);
        end
        for (int i = 0; i < 10; i++)
        begin
            wr(hrm_pkg::OFF_CTRL, 32'h00000500 | 32'(modes[i]));
            wr(hrm_pkg::OFF_CMD, 32'h00000001);
            wr(hrm_pkg::OFF_CMD, 32'h00000002);
            #1 chk(32'({homeRun, cfgError}), i < 6 ? 32'h2 : 32'h1);
            wr(hrm_pkg::OFF_CMD, 32'h00000008);
            #1 chk(32'(cfgError), 32'h0);
        end
        wr(hrm_pkg::OFF_CURTHR, 32'h00000100);
        wr(hrm_pkg::OFF_CTRL, 32'h00003514);
        wr(hrm_pkg::OFF_CMD, 32'h00000001);
        wr(hrm_pkg::OFF_CMD, 32'h00000002);
        #1 chk(32'(searchDir), 32'h0);
        @(posedge mclk) motorCurrent <= 16'h0100;
        @(posedge mclk) motorCurrent <= 16'h0000;
        #1 chk(32'(searchDir), 32'h1);
        @(posedge mclk) swRaw.home <= 1'b1;
        @(posedge mclk) swRaw.home <= 1'b0;
        #1 chk(32'(machineZero), 32'h0);
        waitEv(2);
        chk(32'({homeRun, moveToZero}), 32'h3);
        conclude();
    end
endmodule
